// File: direct_mode_pin_sharing.sv
// direct-mode sharing of serial and interrupt pins
// Function
// [RULE1] route 10 with select high: bit clock on serial out during rx/tx
// [RULE2] select low: serial out carries only serial read data
// [RULE3] route 11, no interrupt enables: bit clock on interrupt pin
// [RULE4] source 01: serial in pin is direct data path, rx and tx
// [RULE5] select low: serial in pin is ordinary serial write data
// [RULE6] select high in tx: host drives bits on serial in, sent
// [RULE7] select high in rx: demodulated bits driven onto serial in
// [RULE8] serial out without bit clock may carry interrupt by select bit
// [RULE9] pseudorandom mode: transmit bits come from internal generator
// [RULE10] synchronous tx bit clock is square wave at data rate; here the low half is held while the tx buffer is full
// [RULE11] host gives one new bit per bit clock cycle
// [RULE12] generator is nine-bit shift register x^9+x^5+1, nonzero seed
`include "pin_share_map.svh"
`default_nettype none

module direct_mode_pin_sharing #(
    parameter int BUF_DEPTH = 2
) (
    // system clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // modem clock domain
    input  wire logic        clk_modem,
    input  wire logic        rx_bit,
    input  wire logic        rx_bit_strobe,
    output logic             tx_mod_bit,
    output logic             tx_mod_strobe,
    // configuration
    input  wire logic [1:0]  clock_route,
    input  wire logic [1:0]  data_source,
    input  wire logic        pn9_enable,
    input  wire logic        sdo_irq_select,
    input  wire logic [7:0]  irq_enable_1,
    input  wire logic [7:0]  irq_enable_2,
    input  wire logic        rx_mode,
    input  wire logic        tx_mode,
    input  wire logic [15:0] bit_half_period,
    // serial core side
    input  wire logic        spi_read_data,
    input  wire logic        spi_read_oe,
    output logic             spi_write_data,
    output logic             spi_write_active,
    input  wire logic        irq_internal_n,
    // pins
    input  wire logic        chip_select_n,
    input  wire logic        sdi_in,
    output logic             sdi_out,
    output logic             sdi_oe,
    output logic             sdo_out,
    output logic             sdo_oe,
    output logic             interrupt_out_n,
    // status
    output logic             tx_buffer_full
);

    pin_share_pkg::sys_state_t   sys_reg;
    pin_share_pkg::sys_state_t   sys_next;
    pin_share_pkg::modem_state_t modem_reg;
    pin_share_pkg::modem_state_t modem_next;

    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_out_data;
    logic        buf_out_ready;
    logic        cs_high;
    logic        run;
    logic        bit_clk;
    logic        sdi_path;
    logic        irq_clk;
    logic        sdo_clk;
    logic [15:0] half_m1;
    logic [8:0]  pn9_step;
    logic        take_pn9;
    logic        take_sdi;
    logic        rx_new;

    // transmit bit buffer in front of the domain crossing
    bit_buffer #(
        .WIDTH (1),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buffer (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (sys_reg.push),
        .in_data   (sys_reg.push_bit),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (buf_out_ready)
    );

    // decoded pin roles
    assign cs_high  = sys_reg.cs_n_s2;
    assign run      = rx_mode | tx_mode;
    assign bit_clk  = (sys_reg.bc == pin_share_pkg::BC_HIGH);
    assign sdi_path = (data_source == `SRC_SDI) & cs_high; // [RULE4]
    assign half_m1  = (bit_half_period == 16'h0000) ? 16'h0000
                      : bit_half_period - 16'h0001;
    assign sdo_clk  = cs_high & run
                      & (clock_route == `ROUTE_SDO);   // [RULE1]
    assign irq_clk  = run & (clock_route == `ROUTE_IRQ)
                      & (irq_enable_1 == 8'h00)
                      & (irq_enable_2 == 8'h00);       // [RULE3]

    // bit source at each rising bit clock edge
    assign take_pn9 = tx_mode & pn9_enable;                  // [RULE9]
    assign take_sdi = tx_mode & ~pn9_enable & sdi_path;      // [RULE6]
    assign pn9_step = {sys_reg.pn9[7:0],
                       sys_reg.pn9[`PN9_TAP_HI]
                       ^ sys_reg.pn9[`PN9_TAP_LO]};          // [RULE12]
    assign rx_new   = (sys_reg.rx_s2 != sys_reg.rx_s3);

    // crossing toward the modem is free when request is answered
    assign buf_out_ready = (sys_reg.hs_req == sys_reg.ack_s2);
    assign tx_buffer_full = ~buf_in_ready;

    // system domain next state
    always_comb
    begin
        sys_next = sys_reg;
        sys_next.cs_n_s1 = chip_select_n;
        sys_next.cs_n_s2 = sys_reg.cs_n_s1;
        sys_next.sdi_s1  = sdi_in;
        sys_next.sdi_s2  = sys_reg.sdi_s1;
        sys_next.ack_s1  = modem_reg.ack;
        sys_next.ack_s2  = sys_reg.ack_s1;
        sys_next.rx_s1   = modem_reg.rx_tgl;
        sys_next.rx_s2   = sys_reg.rx_s1;
        sys_next.rx_s3   = sys_reg.rx_s2;
        sys_next.push    = 1'b0;

        // bit clock at programmed rate; low half held while the tx buffer is full
        case (sys_reg.bc)
            pin_share_pkg::BC_IDLE:
            begin
                if (run)
                begin
                    sys_next.bc  = pin_share_pkg::BC_LOW;
                    sys_next.cnt = 16'h0000;
                end
            end
            pin_share_pkg::BC_LOW:
            begin
                if (!run)
                    sys_next.bc = pin_share_pkg::BC_IDLE;
                else if (sys_reg.cnt < half_m1)
                    sys_next.cnt = sys_reg.cnt + 16'h0001;   // [RULE10]
                else if (buf_in_ready)
                begin
                    // rising edge: take one bit per clock cycle
                    sys_next.bc  = pin_share_pkg::BC_HIGH;
                    sys_next.cnt = 16'h0000;
                    if (take_pn9)
                    begin
                        sys_next.push     = 1'b1;
                        sys_next.push_bit = sys_reg.pn9[`PN9_TAP_HI];
                        sys_next.pn9      = pn9_step;        // [RULE9] [RULE12]
                        // an all-zero register would never leave zero
                        if (pn9_step == 9'h000)
                            sys_next.pn9  = `PN9_SEED;       // [RULE12]
                    end
                    else if (take_sdi)
                    begin
                        sys_next.push     = 1'b1;            // [RULE6] [RULE11]
                        sys_next.push_bit = sys_reg.sdi_s2;
                    end
                end
            end
            pin_share_pkg::BC_HIGH:
            begin
                if (!run)
                    sys_next.bc = pin_share_pkg::BC_IDLE;
                else if (sys_reg.cnt < half_m1)
                    sys_next.cnt = sys_reg.cnt + 16'h0001;   // [RULE10]
                else
                begin
                    sys_next.bc  = pin_share_pkg::BC_LOW;
                    sys_next.cnt = 16'h0000;
                end
            end
            default:
                sys_next.bc = pin_share_pkg::BC_IDLE;
        endcase

        // hand a buffered bit to the modem domain
        if (buf_out_valid && buf_out_ready)
        begin
            sys_next.hs_bit = buf_out_data;
            sys_next.hs_req = ~sys_reg.hs_req;
        end

        // received bit arrives by toggle
        if (rx_new)
            sys_next.rx_bit = modem_reg.rx_hold;

        if (reset)
        begin
            sys_next         = '0;
            sys_next.cs_n_s1 = 1'b1;
            sys_next.cs_n_s2 = 1'b1;
            sys_next.bc      = pin_share_pkg::BC_IDLE;
            sys_next.pn9     = `PN9_SEED;                    // [RULE12]
        end
    end

    always_ff @(posedge clk_sys)
    begin
        sys_reg <= sys_next;
    end

    // modem domain next state
    always_comb
    begin
        modem_next        = modem_reg;
        modem_next.rst_s1 = reset;
        modem_next.rst_s2 = modem_reg.rst_s1;
        modem_next.req_s1 = sys_reg.hs_req;
        modem_next.req_s2 = modem_reg.req_s1;
        modem_next.tx_stb = 1'b0;
        if (modem_reg.req_s2 != modem_reg.ack)
        begin
            modem_next.tx_bit = sys_reg.hs_bit;              // [RULE6]
            modem_next.tx_stb = 1'b1;
            modem_next.ack    = modem_reg.req_s2;
        end
        if (rx_bit_strobe)
        begin
            modem_next.rx_hold = rx_bit;
            modem_next.rx_tgl  = ~modem_reg.rx_tgl;
        end
        if (modem_reg.rst_s2)
        begin
            modem_next.req_s1  = 1'b0;
            modem_next.req_s2  = 1'b0;
            modem_next.ack     = 1'b0;
            modem_next.tx_bit  = 1'b0;
            modem_next.tx_stb  = 1'b0;
            modem_next.rx_tgl  = 1'b0;
            modem_next.rx_hold = 1'b0;
        end
    end

    always_ff @(posedge clk_modem)
    begin
        modem_reg <= modem_next;
    end

    assign tx_mod_bit    = modem_reg.tx_bit;
    assign tx_mod_strobe = modem_reg.tx_stb;

    // serial data in pin: write data or received bits
    assign spi_write_active = ~cs_high;                      // [RULE5]
    assign sdi_oe = sdi_path & rx_mode & ~tx_mode;           // [RULE7]
    always_comb
    begin
        if (cs_high)
        begin
            spi_write_data = 1'b0;
            sdi_out        = sdi_oe ? sys_reg.rx_bit : 1'b0; // [RULE7]
        end
        else
        begin
            spi_write_data = sys_reg.sdi_s2;                 // [RULE5]
            sdi_out        = 1'b0;
        end
    end

    // serial data out pin mux
    always_comb
    begin
        if (!cs_high)
        begin
            sdo_out = spi_read_data;                         // [RULE2]
            sdo_oe  = spi_read_oe;                           // [RULE2]
        end
        else if (sdo_clk)
        begin
            sdo_out = bit_clk;                               // [RULE1]
            sdo_oe  = 1'b1;
        end
        else if (sdo_irq_select)
        begin
            sdo_out = irq_internal_n;                        // [RULE8]
            sdo_oe  = 1'b1;
        end
        else
        begin
            sdo_out = 1'b0;
            sdo_oe  = 1'b0;
        end
    end

    // interrupt pin: bit clock or interrupt
    always_comb
    begin
        if (irq_clk)
            interrupt_out_n = bit_clk;                       // [RULE3]
        else
            interrupt_out_n = irq_internal_n;
    end

endmodule // direct_mode_pin_sharing

`default_nettype wire

// File: pin_share_map.svh
// constants for the direct-mode pin sharing block
`ifndef PIN_SHARE_MAP_SVH
`define PIN_SHARE_MAP_SVH

// clock-route field codes
`define ROUTE_NONE      2'h0
`define ROUTE_GPIO      2'h1
`define ROUTE_SDO       2'h2
`define ROUTE_IRQ       2'h3

// data-source field codes
`define SRC_SDI         2'h1

// pseudorandom generator
`define PN9_SEED        9'h1ff
`define PN9_TAP_HI      8
`define PN9_TAP_LO      4

// bit clock half period in clk_sys cycles
`define BIT_HALF_W      16
`define BIT_HALF_DEF    16'h0064

`endif

// File: pin_share_pkg.sv
// types for the direct-mode pin sharing block
`default_nettype none

package pin_share_pkg;

    typedef enum logic [1:0] {BC_IDLE, BC_LOW, BC_HIGH} bitclk_state_t;

    typedef struct packed {
        logic          cs_n_s1;
        logic          cs_n_s2;
        logic          sdi_s1;
        logic          sdi_s2;
        bitclk_state_t bc;
        logic [15:0]   cnt;
        logic [8:0]    pn9;
        logic          push;
        logic          push_bit;
        logic          hs_req;
        logic          hs_bit;
        logic          ack_s1;
        logic          ack_s2;
        logic          rx_s1;
        logic          rx_s2;
        logic          rx_s3;
        logic          rx_bit;
    } sys_state_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic ack;
        logic tx_bit;
        logic tx_stb;
        logic rx_tgl;
        logic rx_hold;
    } modem_state_t;

endpackage

`default_nettype wire

// File: bit_buffer.sv
// small valid/ready buffer for transmit bits
`default_nettype none

module bit_buffer #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // draining side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
    } buf_state_t;

    buf_state_t buf_reg;
    buf_state_t buf_next;
    logic       do_push;
    logic       do_pop;

    assign in_ready  = (buf_reg.count != AW'(0) + (AW+1)'(DEPTH))
                       ? 1'b1 : 1'b0;
    assign out_valid = (buf_reg.count != '0);
    assign out_data  = buf_reg.mem[buf_reg.rd];

    always_comb
    begin
        buf_next = buf_reg;
        do_push  = in_valid & in_ready;
        do_pop   = out_valid & out_ready;
        if (do_push)
        begin
            buf_next.mem[buf_reg.wr] = in_data;
            buf_next.wr = (buf_reg.wr == AW'(DEPTH - 1)) ? '0
                          : buf_reg.wr + AW'(1);
        end
        if (do_pop)
            buf_next.rd = (buf_reg.rd == AW'(DEPTH - 1)) ? '0
                          : buf_reg.rd + AW'(1);
        if (do_push && !do_pop)
            buf_next.count = buf_reg.count + (AW+1)'(1);
        else if (do_pop && !do_push)
            buf_next.count = buf_reg.count - (AW+1)'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            buf_reg <= '0;
        else
            buf_reg <= buf_next;
    end

endmodule // bit_buffer

`default_nettype wire

// File: dmps_chk.sv
// assertion checker for the direct-mode pin sharing block
`include "pin_share_map.svh"
`default_nettype none
module dmps_chk (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // configuration
    input wire logic [1:0]  clock_route,
    input wire logic [1:0]  data_source,
    input wire logic        sdo_irq_select,
    input wire logic [7:0]  irq_enable_1,
    input wire logic [7:0]  irq_enable_2,
    input wire logic        rx_mode,
    input wire logic        tx_mode,
    input wire logic [15:0] bit_half_period,
    // core side and pins
    input wire logic        spi_read_data,
    input wire logic        spi_read_oe,
    input wire logic        spi_write_active,
    input wire logic        irq_internal_n,
    input wire logic        chip_select_n,
    input wire logic        sdi_oe,
    input wire logic        sdo_out,
    input wire logic        sdo_oe,
    input wire logic        interrupt_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] hi_cnt_reg;
    logic [7:0]  on_cnt_reg;
    wire logic   irq_route = clock_route == `ROUTE_IRQ
        && irq_enable_1 == 8'h00 && irq_enable_2 == 8'h00;
    wire logic   clk_on = (rx_mode || tx_mode) && (irq_route
        || (clock_route == `ROUTE_SDO && chip_select_n));
    wire logic   clk_pin = clock_route == `ROUTE_SDO ? sdo_out
        : interrupt_out_n;
    wire logic   sdo_free = chip_select_n && clock_route != `ROUTE_SDO;
    // high-half length and time the clock has been on
    always_ff @(posedge clk_sys)
    begin
        hi_cnt_reg <= clk_pin ? hi_cnt_reg + 16'h0001 : 16'h0000;
        if (reset || !clk_on)
            on_cnt_reg <= 8'h00;
        else if (on_cnt_reg != 8'h40)
            on_cnt_reg <= on_cnt_reg + 8'h01;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence cs_lo;
        !chip_select_n [*3];
    endsequence
    sequence rx_drv;
        (chip_select_n && data_source == `SRC_SDI && rx_mode
        && !tx_mode) [*3];
    endsequence
    sdo_read_a: assert property (
        cs_lo |-> sdo_oe == spi_read_oe && sdo_out == spi_read_data)
        else $error("sdo not carrying read data");
    sdi_write_a: assert property (
        cs_lo |-> spi_write_active && !sdi_oe)
        else $error("sdi not serial write data");
    sdo_clock_a: assert property (
        (chip_select_n && clock_route == `ROUTE_SDO
        && (rx_mode || tx_mode)) [*3] |-> sdo_oe)
        else $error("sdo not driving bit clock");
    irq_pass_a: assert property (
        (!irq_route && $stable(irq_internal_n)) [*3]
        |-> interrupt_out_n == irq_internal_n)
        else $error("interrupt pin lost interrupt");
    sdo_irq_a: assert property (
        (sdo_free && sdo_irq_select && $stable(irq_internal_n)) [*3]
        |-> sdo_oe && sdo_out == irq_internal_n)
        else $error("sdo not carrying interrupt");
    sdo_off_a: assert property (
        (sdo_free && !sdo_irq_select) [*3] |-> !sdo_oe)
        else $error("sdo driven with no function");
    rx_drive_a: assert property (
        rx_drv |-> sdi_oe)
        else $error("rx bits not driven on sdi");
    tx_float_a: assert property (
        (tx_mode || data_source != `SRC_SDI) [*3] |-> !sdi_oe)
        else $error("sdi driven during transmit");
    half_high_a: assert property (
        clk_on && on_cnt_reg == 8'h40 && $fell(clk_pin)
        |-> hi_cnt_reg == bit_half_period)
        else $error("bit clock high half wrong");
endmodule // dmps_chk
bind direct_mode_pin_sharing dmps_chk u_chk (.clk_sys, .reset,
    .clock_route, .data_source, .sdo_irq_select, .irq_enable_1,
    .irq_enable_2, .rx_mode, .tx_mode, .bit_half_period, .spi_read_data,
    .spi_read_oe, .spi_write_active, .irq_internal_n, .chip_select_n,
    .sdi_oe, .sdo_out, .sdo_oe, .interrupt_out_n);
`default_nettype wire

// File: dmps_host.sv
// host model feeding transmit bits against the bit clock
`default_nettype none
module host_mcu (
    // bit clock and drive control
    input  wire logic        bit_clk,
    input  wire logic        en,
    input  wire logic [15:0] pattern,
    // serial in pin drive
    output logic             sdi_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    int idx = 0;
    initial sdi_drv = 1'b0;
    // first bit ready before the first rise
    always @(posedge en)
    begin
        idx = 0;
        sdi_drv = pattern[15];
    end
    // one new bit after each falling edge
    always @(negedge bit_clk)
        if (en)
        begin
            idx = (idx + 1) % 16;
            sdi_drv = pattern[15 - idx];
        end
    // released pin shows the inverse of the last bit
    always @(negedge en) sdi_drv = ~sdi_drv;
endmodule // host_mcu
`default_nettype wire

// File: test_direct_mode_pin_sharing.sv
// self-checking bench for the direct-mode pin sharing block
`include "pin_share_map.svh"
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module test_direct_mode_pin_sharing;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        clk_modem = 1'b0;
    logic        reset, rx_bit, rx_bit_strobe, pn9_enable, sdo_irq_select;
    logic        rx_mode, tx_mode, spi_read_data, spi_read_oe, b;
    logic        irq_internal_n, chip_select_n, host_en, spi_on, spi_bit;
    logic        seen_full = 1'b0;
    logic [1:0]  clock_route, data_source;
    logic [7:0]  irq_enable_1, irq_enable_2;
    logic [15:0] bit_half_period, pat;
    wire logic   tx_mod_bit, tx_mod_strobe, spi_write_data, spi_write_active;
    wire logic   sdi_out, sdi_oe, sdo_out, sdo_oe, interrupt_out_n;
    wire logic   tx_buffer_full, host_drv;
    wire logic   sdi_in = sdi_oe ? sdi_out : (spi_on ? spi_bit : host_drv);
    logic        q[$];
    logic [1:0]  rt[3] = '{`ROUTE_NONE, `ROUTE_GPIO, `ROUTE_IRQ};
    int          n_mismatch = 0;
    int          checks = 0;
    int          n_hi = 0;
    direct_mode_pin_sharing DUT (.clk_sys, .reset, .clk_modem, .rx_bit,
        .rx_bit_strobe, .tx_mod_bit, .tx_mod_strobe, .clock_route,
        .data_source, .pn9_enable, .sdo_irq_select, .irq_enable_1,
        .irq_enable_2, .rx_mode, .tx_mode, .bit_half_period,
        .spi_read_data, .spi_read_oe, .spi_write_data, .spi_write_active,
        .irq_internal_n, .chip_select_n, .sdi_in, .sdi_out, .sdi_oe,
        .sdo_out, .sdo_oe, .interrupt_out_n, .tx_buffer_full);
    host_mcu u_host (.bit_clk(sdo_out & sdo_oe), .en(host_en),
        .pattern(pat), .sdi_drv(host_drv));
    always #10 clk_sys = ~clk_sys;
    initial
    begin
        #7;
        forever #15 clk_modem = ~clk_modem;
    end
    always @(posedge clk_modem)
        if (tx_mod_strobe === 1'b1)
            q.push_back(tx_mod_bit);
    always @(posedge clk_sys)
        if (tx_buffer_full === 1'b1)
            seen_full <= 1'b1;
    function automatic logic pn9_bit(int k);
        logic [8:0] s;
        s = `PN9_SEED;
        repeat (k) s = {s[7:0], s[8] ^ s[4]};
        return s[8];
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic want_bits(int n);
        int t;
        t = 0;
        while (q.size() < n && t < 5000)
        begin
            cyc(1);
            t++;
        end
        if (t == 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        {rx_bit, rx_bit_strobe, pn9_enable, sdo_irq_select} = 4'h0;
        {rx_mode, tx_mode, spi_read_data, spi_read_oe} = 4'h0;
        {host_en, spi_on, spi_bit, b} = 4'h0;
        {irq_internal_n, chip_select_n} = 2'h3;
        {irq_enable_1, irq_enable_2} = 16'h0000;
        clock_route = `ROUTE_IRQ;
        data_source = `SRC_SDI;
        bit_half_period = 16'h0001;
        pat = 16'h0000;
        void'($urandom(32'hb303));
        cyc(8);
        reset = 1'b0;
        cyc(3);
        // generator bits through a stalling buffer
        {pn9_enable, tx_mode} = 2'h3;
        want_bits(24);
        {pn9_enable, tx_mode} = 2'h0;
        for (int k = 0; k < 24; k++)
            `CHK(q[k], pn9_bit(k))
        `CHK(seen_full, 1'b1)
        $display("test pn9 done");
        cyc(40);
        q.delete();
        // host bits clocked by the sdo bit clock
        bit_half_period = 16'h0006;
        pat = 16'($urandom);
        clock_route = `ROUTE_SDO;
        {tx_mode, host_en} = 2'h3;
        want_bits(12);
        {tx_mode, host_en} = 2'h0;
        for (int k = 0; k < 12; k++)
            `CHK(q[k], pat[15 - k])
        $display("test host tx done");
        rx_mode = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            b = 1'($urandom);
            @(negedge clk_modem) {rx_bit, rx_bit_strobe} = {b, 1'b1};
            @(negedge clk_modem) rx_bit_strobe = 1'b0;
            cyc(8);
            `CHK(sdi_oe, 1'b1)
            `CHK(sdi_out, b)
        end
        rx_mode = 1'b0;
        $display("test rx done");
        {chip_select_n, spi_on, tx_mode} = 3'h3;
        for (int k = 0; k < 8; k++)
        begin
            {spi_read_data, spi_read_oe, spi_bit} = 3'($urandom);
            cyc(4);
            `CHK(sdo_out, spi_read_data)
            `CHK(sdo_oe, spi_read_oe)
            `CHK(spi_write_data, spi_bit)
            `CHK(spi_write_active, 1'b1)
        end
        {chip_select_n, spi_on, tx_mode} = 3'h4;
        $display("test select low done");
        for (int k = 0; k < 9; k++)
        begin
            {sdo_irq_select, irq_internal_n} = 2'($urandom);
            clock_route = rt[k % 3];
            {irq_enable_1, irq_enable_2} = k[0] ? 16'h0080 : 16'h0100;
            cyc(4);
            `CHK(interrupt_out_n, irq_internal_n)
            `CHK(sdo_oe, sdo_irq_select)
            `CHK(spi_write_active, 1'b0)
            if (sdo_irq_select)
                `CHK(sdo_out, irq_internal_n)
        end
        $display("test interrupt routing done");
        // bit clock on the interrupt pin with no enables
        {irq_enable_1, irq_enable_2, irq_internal_n} = 17'h00001;
        clock_route = `ROUTE_IRQ;
        rx_mode = 1'b1;
        cyc(2);
        repeat (24)
        begin
            cyc(1);
            if (interrupt_out_n === 1'b1)
                n_hi++;
        end
        rx_mode = 1'b0;
        `CHK(n_hi, 12)
        $display("test interrupt clock done");
        tally_and_finish();
    end
endmodule // test_direct_mode_pin_sharing
`default_nettype wire
